// file: inc/dfm_pkg.sv
// shared constants for the drive feature manager
package dfm_pkg;
  // set features subcommands
  localparam logic [7:0] SF_WCACHE_ON = 8'h02;
  localparam logic [7:0] SF_PWR_ON = 8'h05;
  localparam logic [7:0] SF_PUIS_ON = 8'h06;
  localparam logic [7:0] SF_SPINUP = 8'h07;
  localparam logic [7:0] SF_OFS_ON = 8'h09;
  localparam logic [7:0] SF_NOISE_ON = 8'h42;
  localparam logic [7:0] SF_REVERT_ON = 8'hCC;
  localparam logic [7:0] SF_WCACHE_OFF = 8'h82;
  localparam logic [7:0] SF_PWR_OFF = 8'h85;
  localparam logic [7:0] SF_PUIS_OFF = 8'h86;
  localparam logic [7:0] SF_OFS_OFF = 8'h89;
  localparam logic [7:0] SF_NOISE_OFF = 8'hC2;
  localparam logic [7:0] SF_REVERT_OFF = 8'h66;
  // commands
  localparam logic [2:0] CMD_SEEK = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_FEAT = 3'h3;
  localparam logic [2:0] CMD_STBY = 3'h4;
  localparam logic [2:0] CMD_FLUSH = 3'h5;
  localparam logic [2:0] CMD_IDENT = 3'h6;
  // level limits
  localparam logic [7:0] LVL_MIN = 8'h01;
  localparam logic [7:0] LVL_MAX = 8'hFE;
  localparam logic [7:0] NOISE_NO_STBY = 8'h80;
  localparam logic [7:0] NOISE_RECOMMEND = 8'h80;
  localparam logic [7:0] PWR_RESET_LVL = 8'h80;
  localparam logic [7:0] NOISE_RESET_LVL = 8'hFE;
  // identify bit positions
  localparam int ID_W0_INCOMPLETE = 2;
  localparam int ID_BIT_PWR = 3;
  localparam int ID_BIT_OFS = 7;
  localparam int ID_BIT_NOISE = 9;
  localparam logic [7:0] SPARE_RESET = 8'h00;
  typedef enum logic [1:0] {
    DFM_IDLE = 2'b00,
    DFM_DEFER = 2'b01
  } dfm_state_t;
endpackage : dfm_pkg

// file: hdl/dfm_core.sv
// feature manager: seek overlap, write cache, reallocation, power and offset features
// Behaviour
// (R1) seek completes early; next physical seek starts when the prior one ends
// (R2) cached writes complete once all data is buffered, media write follows
// (R3) resets never interrupt a running cached media write
// (R4) soft reset, standby and flush wait until cached data is on media
// (R5) reassignment disabled when spare count reaches zero
// (R6) reassignment records apply at once and survive hard or power-on reset
// (R7) failed write relocates; error only if cache off and relocation failed
// (R8) spares at zero with cache on disables auto-reallocation and cache
// (R9) unrecovered read gives hard error and marks a reallocation candidate
// (R10) read recovered at the specific step is reallocated automatically
// (R11) standby-at-power-up via subcommand or jumper; jumper wins; persistent
// (R12) after power-up standby, stay there until spin-up subcommand
// (R13) identify in power-up standby sets word 0 bit 2 incomplete
// (R14) power-saving levels 01h to FEh, separate enable and disable
// (R15) standby on timer, power algorithm or noise algorithm, independently
// (R16) identify shows power-saving support, enable and level
// (R17) noise levels 80h and above never cause standby
// (R18) identify shows noise support, enable, level and recommended level
// (R19) subcommand 09h offsets address zero to protected area start, wrapping
// (R20) offset cleared by 89h, hard or power-on reset, soft reset if revert on
// (R21) enable offset without protected area aborts
// (R22) offset capacity is protected size; disable restores nonvolatile max
// (R23) in offset mode, ranges spanning native max are rejected
// (R24) identify shows offset support and offset mode in bit 7
`timescale 1ns/10ps
`default_nettype none
module dfm_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // reset events
  input wire logic hard_rst,
  input wire logic soft_rst,
  input wire logic puis_jumper,
  // command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [7:0] cmd_feature,
  input wire logic [7:0] cmd_count,
  input wire logic [31:0] cmd_lba,
  input wire logic [31:0] cmd_len,
  // media engine
  input wire logic seek_busy,
  input wire logic media_wr_busy,
  input wire logic wr_data_all,
  input wire logic wr_fail,
  input wire logic reloc_fail,
  input wire logic rd_fail,
  input wire logic rd_recovered,
  input wire logic [7:0] spare_count,
  input wire logic stby_timer_exp,
  input wire logic pwr_alg_stby,
  input wire logic noise_alg_stby,
  input wire logic [31:0] native_max,
  input wire logic [31:0] nv_max,
  input wire logic nv_area_set,
  // outputs
  output logic cmd_done,
  output logic cmd_abort,
  output logic cmd_err,
  output logic seek_start,
  output logic media_wr_start,
  output logic reloc_req,
  output logic verify_req,
  output logic in_standby,
  output logic [31:0] phys_lba,
  output logic [31:0] capacity,
  output logic [15:0] id_w0,
  output logic [15:0] id_w83,
  output logic [15:0] id_w86,
  output logic [15:0] id_w91,
  output logic [15:0] id_w94,
  output logic wcache_on,
  output logic reassign_on
);
  // ==========================================
  // state
  logic done_q, abort_q, err_q, sstart_q, mwstart_q, reloc_q, verify_q;
  logic seek_pend_q, wc_q, ra_q, puis_q, pu_stby_q, stby_q, pwr_en_q, noise_en_q;
  logic ofs_q, revert_q, cand_q;
  logic [7:0] pwr_lvl_q, noise_lvl_q;
  logic [31:0] cand_lba_q, plba_q, cap_q;
  logic hr_s1_q, hr_s2_q, sr_s1_q, sr_s2_q, jp_s1_q, jp_s2_q, sr_pend_q;
  dfm_pkg::dfm_state_t st_q;
  logic [2:0] def_cmd_q;

  // ==========================================
  // decode
  wire logic is_feat = cmd_valid && cmd_code == dfm_pkg::CMD_FEAT;
  wire logic sf_ofs_on = is_feat && cmd_feature == dfm_pkg::SF_OFS_ON;
  wire logic sf_ofs_off = is_feat && cmd_feature == dfm_pkg::SF_OFS_OFF;
  wire logic lvl_ok = cmd_count >= dfm_pkg::LVL_MIN && cmd_count <= dfm_pkg::LVL_MAX; // R14
  wire logic cache_busy = media_wr_busy; // R4
  wire logic defer_cmd = cmd_valid && (cmd_code == dfm_pkg::CMD_STBY ||
                         cmd_code == dfm_pkg::CMD_FLUSH) && cache_busy; // R4
  wire logic [31:0] last_lba = cmd_lba + cmd_len - 32'h00000001;
  // last logical address before the offset space wraps past native max
  wire logic [31:0] ofs_edge = native_max - nv_max - 32'h00000001; // R23
  wire logic spans_native = ofs_q && cmd_len != 32'h00000000 &&
                            cmd_lba <= ofs_edge && last_lba > ofs_edge; // R23
  wire logic [31:0] ofs_sum = cmd_lba + nv_max + 32'h00000001; // R19
  wire logic [31:0] wrap_lba = (ofs_sum > native_max) ?
                               ofs_sum - native_max - 32'h00000001 : ofs_sum; // R19
  wire logic xfer = cmd_valid && (cmd_code == dfm_pkg::CMD_WRITE ||
                    cmd_code == dfm_pkg::CMD_READ);
  wire logic spares_out = spare_count == 8'h00; // R5
  wire logic noise_stby = noise_en_q && noise_lvl_q < dfm_pkg::NOISE_NO_STBY &&
                          noise_alg_stby; // R17
  wire logic go_stby = stby_timer_exp || (pwr_en_q && pwr_alg_stby) || noise_stby; // R15
  wire logic hard_ev = hr_s2_q;
  wire logic soft_ev = sr_s2_q;
  wire logic write_hit = cmd_valid && cmd_code == dfm_pkg::CMD_WRITE && cand_q &&
                         cmd_lba == cand_lba_q; // R9

  // ==========================================
  // pin synchronisers
  always_ff @(posedge sys_clk) begin
    hr_s1_q <= hard_rst;
    hr_s2_q <= hr_s1_q;
    sr_s1_q <= soft_rst;
    sr_s2_q <= sr_s1_q;
    jp_s1_q <= puis_jumper;
    jp_s2_q <= jp_s1_q;
  end

  // ==========================================
  // command sequencing and pulses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      abort_q <= 1'b0;
      err_q <= 1'b0;
      sstart_q <= 1'b0;
      seek_pend_q <= 1'b0;
      mwstart_q <= 1'b0;
      st_q <= dfm_pkg::DFM_IDLE;
      def_cmd_q <= 3'h0;
      sr_pend_q <= 1'b0;
      plba_q <= 32'h00000000;
    end else begin
      done_q <= 1'b0;
      abort_q <= 1'b0;
      err_q <= 1'b0;
      sstart_q <= 1'b0;
      mwstart_q <= 1'b0;
      if (soft_ev && cache_busy) begin
        sr_pend_q <= 1'b1; // R4 R3
      end else if (!cache_busy) begin
        sr_pend_q <= 1'b0;
      end
      if (seek_pend_q && !seek_busy && !sstart_q) begin
        sstart_q <= 1'b1; // R1
        seek_pend_q <= 1'b0;
      end
      unique case (st_q)
        dfm_pkg::DFM_IDLE: begin
          if (defer_cmd) begin
            st_q <= dfm_pkg::DFM_DEFER; // R4
            def_cmd_q <= cmd_code;
          end else if (cmd_valid && cmd_code == dfm_pkg::CMD_SEEK) begin
            done_q <= 1'b1; // R1
            if (seek_busy || seek_pend_q) begin
              seek_pend_q <= 1'b1;
            end else begin
              sstart_q <= 1'b1;
            end
          end else if (xfer && spans_native) begin
            abort_q <= 1'b1; // R23
            err_q <= 1'b1;
          end else if (sf_ofs_on && !nv_area_set) begin
            abort_q <= 1'b1; // R21
            err_q <= 1'b1;
          end else if (is_feat && (cmd_feature == dfm_pkg::SF_PWR_ON ||
                       cmd_feature == dfm_pkg::SF_NOISE_ON) && !lvl_ok) begin
            abort_q <= 1'b1; // R14
            err_q <= 1'b1;
          end else if (is_feat && cmd_feature == dfm_pkg::SF_PUIS_OFF && jp_s2_q) begin
            abort_q <= 1'b1; // R11
            err_q <= 1'b1;
          end else if (cmd_valid && cmd_code == dfm_pkg::CMD_WRITE) begin
            if (wc_q) begin
              if (wr_data_all) begin
                done_q <= 1'b1; // R2
                mwstart_q <= 1'b1;
              end
            end else begin
              done_q <= 1'b1;
              mwstart_q <= 1'b1;
            end
            plba_q <= ofs_q ? wrap_lba : cmd_lba;
          end else if (cmd_valid && cmd_code == dfm_pkg::CMD_READ) begin
            done_q <= 1'b1;
            err_q <= rd_fail; // R9
            plba_q <= ofs_q ? wrap_lba : cmd_lba; // R19
          end else if (cmd_valid) begin
            done_q <= 1'b1;
          end
          if (wr_fail && !wc_q && reloc_fail) begin
            err_q <= 1'b1; // R7
          end
        end
        dfm_pkg::DFM_DEFER: begin
          if (!cache_busy) begin
            st_q <= dfm_pkg::DFM_IDLE; // R4
            done_q <= 1'b1;
          end
        end
        default: st_q <= dfm_pkg::DFM_IDLE;
      endcase
    end
  end

  // ==========================================
  // features and standby
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wc_q <= 1'b1;
      ra_q <= 1'b1;
      puis_q <= 1'b0;
      pu_stby_q <= 1'b0;
      stby_q <= 1'b0;
      pwr_en_q <= 1'b0;
      noise_en_q <= 1'b0;
      pwr_lvl_q <= dfm_pkg::PWR_RESET_LVL;
      noise_lvl_q <= dfm_pkg::NOISE_RESET_LVL;
      ofs_q <= 1'b0;
      revert_q <= 1'b0;
    end else begin
      if (spares_out) begin
        ra_q <= 1'b0; // R5
        if (wc_q) begin
          wc_q <= 1'b0; // R8
        end
      end else if (is_feat && cmd_feature == dfm_pkg::SF_WCACHE_ON) begin
        wc_q <= 1'b1;
      end else if (is_feat && cmd_feature == dfm_pkg::SF_WCACHE_OFF) begin
        wc_q <= 1'b0;
      end
      if (is_feat && cmd_feature == dfm_pkg::SF_PUIS_ON) begin
        puis_q <= 1'b1; // R11
      end else if (is_feat && cmd_feature == dfm_pkg::SF_PUIS_OFF && !jp_s2_q) begin
        puis_q <= 1'b0; // R11
      end
      if (hard_ev && (puis_q || jp_s2_q)) begin
        pu_stby_q <= 1'b1; // R12
        stby_q <= 1'b1;
      end else if (is_feat && cmd_feature == dfm_pkg::SF_SPINUP) begin
        pu_stby_q <= 1'b0; // R12
        stby_q <= 1'b0;
      end else if (!pu_stby_q) begin
        if (go_stby || (st_q == dfm_pkg::DFM_DEFER && !cache_busy &&
            def_cmd_q == dfm_pkg::CMD_STBY)) begin
          stby_q <= 1'b1; // R15
        end else if (xfer) begin
          stby_q <= 1'b0;
        end
      end
      if (is_feat && cmd_feature == dfm_pkg::SF_PWR_ON && lvl_ok) begin
        pwr_en_q <= 1'b1; // R14
        pwr_lvl_q <= cmd_count;
      end else if (is_feat && cmd_feature == dfm_pkg::SF_PWR_OFF) begin
        pwr_en_q <= 1'b0;
      end
      if (is_feat && cmd_feature == dfm_pkg::SF_NOISE_ON && lvl_ok) begin
        noise_en_q <= 1'b1;
        noise_lvl_q <= cmd_count;
      end else if (is_feat && cmd_feature == dfm_pkg::SF_NOISE_OFF) begin
        noise_en_q <= 1'b0;
      end
      if (is_feat && cmd_feature == dfm_pkg::SF_REVERT_ON) begin
        revert_q <= 1'b1;
      end else if (is_feat && cmd_feature == dfm_pkg::SF_REVERT_OFF) begin
        revert_q <= 1'b0;
      end
      if (hard_ev || sf_ofs_off || ((soft_ev || sr_pend_q) && !cache_busy && revert_q)) begin
        ofs_q <= 1'b0; // R20
      end else if (sf_ofs_on && nv_area_set) begin
        ofs_q <= 1'b1; // R19
      end
    end
  end

  // ==========================================
  // reallocation; records live in the media engine and survive resets
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reloc_q <= 1'b0;
      verify_q <= 1'b0;
      cand_q <= 1'b0;
      cand_lba_q <= 32'h00000000;
      cap_q <= 32'h00000000;
    end else begin
      reloc_q <= ra_q && !spares_out && (wr_fail || rd_recovered); // R7 R10 R6
      verify_q <= ra_q && write_hit; // R9
      if (rd_fail && cmd_valid && cmd_code == dfm_pkg::CMD_READ) begin
        cand_q <= 1'b1; // R9
        cand_lba_q <= cmd_lba;
      end else if (write_hit) begin
        cand_q <= 1'b0;
      end
      cap_q <= ofs_q ? native_max - nv_max : nv_max + 32'h00000001; // R22
    end
  end

  // ==========================================
  // outputs
  always_comb begin
    cmd_done = done_q;
    cmd_abort = abort_q;
    cmd_err = err_q;
    seek_start = sstart_q;
    media_wr_start = mwstart_q;
    reloc_req = reloc_q;
    verify_req = verify_q;
    in_standby = stby_q;
    phys_lba = plba_q;
    capacity = cap_q;
    wcache_on = wc_q;
    reassign_on = ra_q;
    id_w0 = 16'h0000;
    id_w0[dfm_pkg::ID_W0_INCOMPLETE] = pu_stby_q; // R13
    id_w83 = 16'h0000;
    id_w83[dfm_pkg::ID_BIT_PWR] = 1'b1; // R16
    id_w83[dfm_pkg::ID_BIT_OFS] = 1'b1; // R24
    id_w83[dfm_pkg::ID_BIT_NOISE] = 1'b1; // R18
    id_w86 = 16'h0000;
    id_w86[dfm_pkg::ID_BIT_PWR] = pwr_en_q;
    id_w86[dfm_pkg::ID_BIT_OFS] = ofs_q; // R24
    id_w86[dfm_pkg::ID_BIT_NOISE] = noise_en_q;
    id_w91 = {8'h00, pwr_en_q ? pwr_lvl_q : 8'h00}; // R16
    id_w94 = {dfm_pkg::NOISE_RECOMMEND, noise_en_q ? noise_lvl_q : 8'h00}; // R18
  end

  // ==========================================
  // checks
  a_flush_defer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == dfm_pkg::DFM_DEFER && cache_busy |=> !done_q) // R4
    else $error("deferred command completed while cache busy");
  a_spare_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    spares_out |=> !ra_q && !wc_q) // R5 R8
    else $error("reassign or cache still on with no spares");
  a_ofs_abort: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == dfm_pkg::DFM_IDLE && !defer_cmd && sf_ofs_on && !nv_area_set
    |=> abort_q && !ofs_q) // R21
    else $error("offset enable without protected area not aborted");
  a_noise_hi: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !stby_q && !pu_stby_q && !stby_timer_exp && !(pwr_en_q && pwr_alg_stby) &&
    noise_lvl_q >= dfm_pkg::NOISE_NO_STBY && !defer_cmd && st_q == dfm_pkg::DFM_IDLE
    && !hard_ev |=> !stby_q) // R17
    else $error("high noise level caused standby");
  a_spinup_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pu_stby_q && !(is_feat && cmd_feature == dfm_pkg::SF_SPINUP) |=> stby_q) // R12
    else $error("left power-up standby without spin-up");
  a_ofs_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sf_ofs_off || hard_ev |=> !ofs_q) // R20
    else $error("offset not cleared");
  a_span_rej: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == dfm_pkg::DFM_IDLE && !defer_cmd && xfer && spans_native
    |=> abort_q && err_q) // R23
    else $error("span over native max not rejected");
  a_seek_early: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == dfm_pkg::DFM_IDLE && !defer_cmd && cmd_valid &&
    cmd_code == dfm_pkg::CMD_SEEK |=> done_q) // R1
    else $error("seek not completed at once");
endmodule : dfm_core
`default_nettype wire

// file: tb/dfm_media_model.sv
// media engine model: seek and media write busy timing
`timescale 1ns/10ps
`default_nettype none
module dfm_media_model #(
  parameter int SEEK_CYC = 20,
  parameter int WR_CYC = 30
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // requests from the block
  input wire logic seek_start,
  input wire logic media_wr_start,
  // busy levels back
  output logic seek_busy,
  output logic media_wr_busy
);
  int seek_n_q;
  int wr_n_q;
  assign seek_busy = (seek_n_q != 0);
  assign media_wr_busy = (wr_n_q != 0);
  // media write runs on through every reset, sys_rst included; only the end of its WR_CYC count ends it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seek_n_q <= 0;
    end else if (seek_start) begin
      seek_n_q <= SEEK_CYC;
    end else if (seek_n_q != 0) begin
      seek_n_q <= seek_n_q - 1;
    end
    if (media_wr_start) begin
      wr_n_q <= WR_CYC;
    end else if (wr_n_q != 0) begin
      wr_n_q <= wr_n_q - 1;
    end
  end
endmodule : dfm_media_model
`default_nettype wire

// file: tb/dfm_core_tb.sv
// self-checking bench for the feature manager
`timescale 1ns/10ps
`default_nettype none
module dfm_core_tb;
  localparam int SEEK_CYC = 20;
  localparam logic [31:0] NATIVE = 32'h0000_1000;
  localparam logic [31:0] NVMAX = 32'h0000_0C00;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hard_rst = 1'b0, soft_rst = 1'b0, puis_jumper = 1'b0, cmd_valid = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic [7:0] cmd_feature = 8'h00, cmd_count = 8'h00, spare_count = 8'h10;
  logic [31:0] cmd_lba = 32'h0, cmd_len = 32'h1;
  logic seek_busy, media_wr_busy, wr_data_all = 1'b1, wr_fail = 1'b0, reloc_fail = 1'b0;
  logic rd_fail = 1'b0, rd_recovered = 1'b0, stby_timer_exp = 1'b0, pwr_alg_stby = 1'b0;
  logic noise_alg_stby = 1'b0, nv_area_set = 1'b0;
  logic cmd_done, cmd_abort, cmd_err, seek_start, media_wr_start, reloc_req, verify_req;
  logic in_standby, wcache_on, reassign_on, last_err;
  logic [31:0] phys_lba, capacity;
  logic [15:0] id_w0, id_w83, id_w86, id_w91, id_w94;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;

  always #5 sys_clk = ~sys_clk;

  dfm_core dfm_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .hard_rst(hard_rst),
    .soft_rst(soft_rst), .puis_jumper(puis_jumper), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_feature(cmd_feature), .cmd_count(cmd_count),
    .cmd_lba(cmd_lba), .cmd_len(cmd_len), .seek_busy(seek_busy),
    .media_wr_busy(media_wr_busy), .wr_data_all(wr_data_all), .wr_fail(wr_fail),
    .reloc_fail(reloc_fail), .rd_fail(rd_fail), .rd_recovered(rd_recovered),
    .spare_count(spare_count), .stby_timer_exp(stby_timer_exp),
    .pwr_alg_stby(pwr_alg_stby), .noise_alg_stby(noise_alg_stby),
    .native_max(NATIVE), .nv_max(NVMAX), .nv_area_set(nv_area_set),
    .cmd_done(cmd_done), .cmd_abort(cmd_abort), .cmd_err(cmd_err),
    .seek_start(seek_start), .media_wr_start(media_wr_start), .reloc_req(reloc_req),
    .verify_req(verify_req), .in_standby(in_standby), .phys_lba(phys_lba),
    .capacity(capacity), .id_w0(id_w0), .id_w83(id_w83), .id_w86(id_w86),
    .id_w91(id_w91), .id_w94(id_w94), .wcache_on(wcache_on), .reassign_on(reassign_on));

  dfm_media_model #(.SEEK_CYC(SEEK_CYC), .WR_CYC(30)) dfm_media_model_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .seek_start(seek_start),
    .media_wr_start(media_wr_start), .seek_busy(seek_busy), .media_wr_busy(media_wr_busy));

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk

  // one request, then bounded wait for done or abort
  task automatic cmd(input logic [2:0] c, input logic [7:0] f, input logic [7:0] cnt,
                     input logic [31:0] lba, input logic [31:0] len, input logic ab);
    int k;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_feature <= f;
    cmd_count <= cnt;
    cmd_lba <= lba;
    cmd_len <= len;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    for (k = 0; k < 200 && cmd_done !== 1'b1 && cmd_abort !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    last_err = cmd_err;
    chk((cmd_done | cmd_abort) === 1'b1, "no answer to request");
    chk(cmd_abort === ab, "abort state differs");
  endtask : cmd

  task automatic feat(input logic [7:0] f, input logic [7:0] cnt, input logic ab);
    cmd(dfm_pkg::CMD_FEAT, f, cnt, 32'h0, 32'h1, ab);
  endtask : feat

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    #300000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(wcache_on === 1'b1 && reassign_on === 1'b1, "reset feature state");
    chk(id_w83[9] === 1'b1 && id_w83[7] === 1'b1 && id_w83[3] === 1'b1, "support bits");
    chk(id_w94 === 16'h8000, "noise word at reset");
    // seek overlap
    cmd(dfm_pkg::CMD_SEEK, 8'h00, 8'h00, 32'h10, 32'h1, 1'b0);
    cmd(dfm_pkg::CMD_SEEK, 8'h00, 8'h00, 32'h20, 32'h1, 1'b0);
    chk(seek_busy === 1'b1, "second seek not completed early");
    for (n = 0; n < 100 && seek_start !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(seek_start === 1'b1 && n > SEEK_CYC / 2, "queued seek start timing");
    // cached write, then flush deferred until media write ends
    cmd(dfm_pkg::CMD_WRITE, 8'h00, 8'h00, 32'h40, 32'h8, 1'b0);
    @(posedge sys_clk);
    #1;
    chk(media_wr_busy === 1'b1, "media write follows completion");
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    cmd(dfm_pkg::CMD_FLUSH, 8'h00, 8'h00, 32'h0, 32'h1, 1'b0);
    chk(media_wr_busy === 1'b0, "flush answered before media write end");
    // power saving levels
    feat(dfm_pkg::SF_PWR_ON, 8'h00, 1'b1);
    feat(dfm_pkg::SF_PWR_ON, 8'hFF, 1'b1);
    feat(dfm_pkg::SF_PWR_ON, 8'h01, 1'b0);
    chk(id_w86[3] === 1'b1 && id_w91[7:0] === 8'h01, "power level word");
    feat(dfm_pkg::SF_PWR_ON, 8'hFE, 1'b0);
    chk(id_w91[7:0] === 8'hFE, "power level top");
    feat(dfm_pkg::SF_PWR_OFF, 8'h00, 1'b0);
    chk(id_w86[3] === 1'b0, "power disable");
    // address offset
    feat(dfm_pkg::SF_OFS_ON, 8'h00, 1'b1);
    nv_area_set <= 1'b1;
    feat(dfm_pkg::SF_OFS_ON, 8'h00, 1'b0);
    chk(id_w86[7] === 1'b1, "offset mode flag");
    cmd(dfm_pkg::CMD_READ, 8'h00, 8'h00, 32'h0, 32'h1, 1'b0);
    chk(phys_lba === NVMAX + 32'h1, "lba zero mapped to protected start");
    chk(capacity === NATIVE - NVMAX, "offset capacity");
    cmd(dfm_pkg::CMD_READ, 8'h00, 8'h00, NATIVE - NVMAX - 32'h1, 32'h2, 1'b1);
    chk(last_err === 1'b1, "span over native max error");
    feat(dfm_pkg::SF_OFS_OFF, 8'h00, 1'b0);
    chk(id_w86[7] === 1'b0, "offset disable");
    feat(dfm_pkg::SF_OFS_ON, 8'h00, 1'b0);
    // noise levels and standby
    feat(dfm_pkg::SF_NOISE_ON, 8'h80, 1'b0);
    chk(id_w86[9] === 1'b1 && id_w94 === 16'h8080, "noise word");
    noise_alg_stby <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(in_standby === 1'b0, "noise level 80h entered standby");
    feat(dfm_pkg::SF_NOISE_ON, 8'h7F, 1'b0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(in_standby === 1'b1, "noise algorithm standby");
    noise_alg_stby <= 1'b0;
    feat(dfm_pkg::SF_SPINUP, 8'h00, 1'b0);
    // power-up standby by jumper; hard reset models power-up
    puis_jumper <= 1'b1;
    hard_rst <= 1'b1;
    @(posedge sys_clk);
    hard_rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    chk(in_standby === 1'b1 && id_w86[7] === 1'b0, "power-up standby, offset cleared");
    cmd(dfm_pkg::CMD_IDENT, 8'h00, 8'h00, 32'h0, 32'h1, 1'b0);
    chk(id_w0[2] === 1'b1, "identify incomplete");
    feat(dfm_pkg::SF_PUIS_OFF, 8'h00, 1'b1);
    repeat (5) @(posedge sys_clk);
    #1;
    chk(in_standby === 1'b1, "left standby without spin-up");
    feat(dfm_pkg::SF_SPINUP, 8'h00, 1'b0);
    chk(in_standby === 1'b0, "spin-up");
    // failed read marks a candidate; a write there asks for verification
    rd_fail <= 1'b1;
    cmd(dfm_pkg::CMD_READ, 8'h00, 8'h00, 32'h30, 32'h1, 1'b0);
    chk(last_err === 1'b1, "unrecovered read not reported");
    rd_fail <= 1'b0;
    cmd(dfm_pkg::CMD_WRITE, 8'h00, 8'h00, 32'h30, 32'h1, 1'b0);
    chk(verify_req === 1'b1, "candidate write without verify");
    cmd(dfm_pkg::CMD_STBY, 8'h00, 8'h00, 32'h0, 32'h1, 1'b0);
    chk(media_wr_busy === 1'b0 && in_standby === 1'b1, "standby not deferred");
    // soft reset clears offset once revert is on
    feat(dfm_pkg::SF_REVERT_ON, 8'h00, 1'b0);
    feat(dfm_pkg::SF_OFS_ON, 8'h00, 1'b0);
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(id_w86[7] === 1'b0 && capacity === NVMAX + 32'h1, "soft reset offset clear");
    // recovered read and write failures
    rd_recovered <= 1'b1;
    @(posedge sys_clk);
    rd_recovered <= 1'b0;
    #1;
    chk(reloc_req === 1'b1, "recovered read not reallocated");
    feat(dfm_pkg::SF_WCACHE_OFF, 8'h00, 1'b0);
    wr_fail <= 1'b1;
    reloc_fail <= 1'b1;
    @(posedge sys_clk);
    wr_fail <= 1'b0;
    reloc_fail <= 1'b0;
    #1;
    chk(cmd_err === 1'b1 && reloc_req === 1'b1, "uncached failed relocation");
    feat(dfm_pkg::SF_WCACHE_ON, 8'h00, 1'b0);
    wr_fail <= 1'b1;
    reloc_fail <= 1'b1;
    @(posedge sys_clk);
    wr_fail <= 1'b0;
    reloc_fail <= 1'b0;
    #1;
    chk(cmd_err === 1'b0 && reloc_req === 1'b1, "cached failure reported");
    // spares exhausted with cache on
    spare_count <= 8'h00;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(reassign_on === 1'b0 && wcache_on === 1'b0, "spares gone");
    close_out();
  end
endmodule : dfm_core_tb
`default_nettype wire
